// >>> src/motor_pwm_irq_shutoff.sv
/*
 * Interrupt flags, flag clearing, write contention and module stop of the
 * motor PWM timer, plus the output shutoff circuit driven by four active-low
 * shutdown inputs. APB slave, zero wait states.
 * Assumes the up/down counter, waveform logic and buffer-transfer timing
 * live outside and run on i_mclk; shutdown inputs are asynchronous pins.
 */
// The register offsets and the APB interface to the registers were chosen for this implementation.
//
// Contract
// - counter equal to period compare sets peak flag; enabled flag requests interrupt.
// - counter equal to twice dead time sets trough flag; enabled flag requests interrupt.
// - timer interrupt request stays asserted until its flag is cleared.
// - peak and trough events also request the data transfer controller.
// - software clears timer flag only by writing 0 after reading it as 1.
// - transfer controller activation clears the flag that triggered it.
// - after reset module stop halts timer and blocks its register access.
// - match during buffer write loads the new write data into compare.
// - match during compare write drops the write, loads from buffer.
// - any shutdown request puts six phase outputs and carrier output hi-z.
// - each shutdown input uses falling edge or sixteen low samples at /8,/16,/128.
// - shutdown interrupt enable bit 8 gates any shutdown flag onto interrupt.
// - shutdown flags sit in bits 15:12 for inputs 3:0, set on detection.
// - shutdown flag clears by reading 1 then writing 0; writing 1 ignored.
// - detect mode field of input n sits in bits 2n+1:2n.
// - mode 00 edge, 01 div 8, 10 div 16, 11 div 128 sampling.
// - bits 11:9 of shutdown register read as zero.
// - shutdown register reset by system reset, kept otherwise.
// - shutdown control/status is one 16-bit read/write register.
`timescale 1ns/1ps
`default_nettype none

module motor_pwm_irq_shutoff (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic [15:0] i_updown_counter,
    input wire logic i_buffer_load,
    input wire logic i_peak_xfer_ack,
    input wire logic i_trough_xfer_ack,
    input wire logic [3:0] i_shutdown_in_n,
    input wire logic [5:0] i_phase_level,
    input wire logic i_carrier_level,
    output logic o_timer_run,
    output logic o_peak_match_irq,
    output logic o_trough_match_irq,
    output logic o_peak_xfer_req,
    output logic o_trough_xfer_req,
    output logic o_shutdown_irq,
    output logic [15:0] o_period_compare,
    output logic [15:0] o_duty_compare_u,
    output logic [15:0] o_duty_compare_v,
    output logic [15:0] o_duty_compare_w,
    output logic [5:0] o_phase_out,
    output logic [5:0] o_phase_oe_n,
    output logic o_carrier_toggle_out,
    output logic o_carrier_oe_n
);
    localparam int RW = motor_pwm_pkg::REG_W;
    localparam int NP = motor_pwm_pkg::NUM_PHASE;
    localparam int NS = motor_pwm_pkg::NUM_SD;

    function automatic logic [motor_pwm_pkg::PRESC_W-1:0] div_mask(input logic [1:0] mode);
        case (mode)
            motor_pwm_pkg::DET_DIV8: div_mask = motor_pwm_pkg::MASK_DIV8;
            motor_pwm_pkg::DET_DIV16: div_mask = motor_pwm_pkg::MASK_DIV16;
            default: div_mask = motor_pwm_pkg::MASK_DIV128;
        endcase
    endfunction : div_mask

    function automatic logic at_phase(input logic [7:0] addr, input logic [7:0] base, input int idx);
        at_phase = (addr == 8'(base + 8'(idx) * motor_pwm_pkg::ADDR_STEP));
    endfunction : at_phase

    logic stop_q;
    logic [1:0] irq_en_q;
    logic [1:0] tflag_q;
    logic [1:0] tarm_q;
    logic [RW-1:0] period_buf_q;
    logic [RW-1:0] period_cmp_q;
    logic [RW-1:0] dead_time_q;
    logic [RW-1:0] duty_buf_q [NP];
    logic [RW-1:0] duty_cmp_q [NP];
    logic [2*NS-1:0] sd_mode_q;
    logic sd_pie_q;
    logic [NS-1:0] sd_flag_q;
    logic [NS-1:0] sd_arm_q;
    logic [31:0] rdata_q;
    logic peak_eq_q;
    logic trough_eq_q;

    // apb decode
    logic setup, access, wr, rd, mapped, timer_addr, ok;
    logic [NP-1:0] hit_dbuf, hit_dcmp;
    logic [31:0] rdata_d;
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            hit_dbuf[i] = at_phase(i_paddr, motor_pwm_pkg::ADDR_DUTY_BUF0, i);
            hit_dcmp[i] = at_phase(i_paddr, motor_pwm_pkg::ADDR_DUTY_CMP0, i);
        end
    end
    assign timer_addr = (i_paddr == motor_pwm_pkg::ADDR_IRQ_CTRL) || (i_paddr == motor_pwm_pkg::ADDR_FLAGS)
        || (i_paddr == motor_pwm_pkg::ADDR_PERIOD_BUF) || (i_paddr == motor_pwm_pkg::ADDR_PERIOD_CMP)
        || (i_paddr == motor_pwm_pkg::ADDR_DEAD_TIME) || (|hit_dbuf) || (|hit_dcmp);
    assign mapped = timer_addr || (i_paddr == motor_pwm_pkg::ADDR_STOP)
        || (i_paddr == motor_pwm_pkg::ADDR_SHUTDOWN);
    assign ok = mapped && !(timer_addr && stop_q);
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite && ok;
    assign rd = access && !i_pwrite && ok;
    assign o_pready = 1'b1;
    assign o_pslverr = access && !ok;
    assign o_prdata = rdata_q;

    always_comb begin
        rdata_d = '0;
        case (i_paddr)
            motor_pwm_pkg::ADDR_STOP: rdata_d[motor_pwm_pkg::STOP_BIT] = stop_q;
            motor_pwm_pkg::ADDR_IRQ_CTRL: rdata_d[1:0] = irq_en_q;
            motor_pwm_pkg::ADDR_FLAGS: rdata_d[1:0] = tflag_q;
            motor_pwm_pkg::ADDR_PERIOD_BUF: rdata_d[RW-1:0] = period_buf_q;
            motor_pwm_pkg::ADDR_PERIOD_CMP: rdata_d[RW-1:0] = period_cmp_q;
            motor_pwm_pkg::ADDR_DEAD_TIME: rdata_d[RW-1:0] = dead_time_q;
            motor_pwm_pkg::ADDR_SHUTDOWN: begin
                // reserved 11:9 stay zero
                rdata_d[motor_pwm_pkg::SD_FLAG_LSB +: NS] = sd_flag_q;
                rdata_d[motor_pwm_pkg::SD_PIE_BIT] = sd_pie_q;
                rdata_d[2*NS-1:0] = sd_mode_q;
            end
            default: begin
                for (int i = 0; i < NP; i++) begin
                    if (hit_dbuf[i]) begin
                        rdata_d[RW-1:0] = duty_buf_q[i];
                    end
                    if (hit_dcmp[i]) begin
                        rdata_d[RW-1:0] = duty_cmp_q[i];
                    end
                end
            end
        endcase
        if (!ok) begin
            rdata_d = '0;
        end
    end

    // read data captured in the setup phase so it comes from a flop
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= '0;
        end else if (setup && !i_pwrite) begin
            rdata_q <= rdata_d;
        end
    end

    // module stop and control
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stop_q <= motor_pwm_pkg::STOP_RST;
            irq_en_q <= motor_pwm_pkg::FLAG_RST;
            dead_time_q <= motor_pwm_pkg::REG_RST;
        end else if (wr) begin
            if (i_paddr == motor_pwm_pkg::ADDR_STOP) begin
                stop_q <= i_pwdata[motor_pwm_pkg::STOP_BIT];
            end
            if (i_paddr == motor_pwm_pkg::ADDR_IRQ_CTRL) begin
                irq_en_q <= i_pwdata[1:0];
            end
            if (i_paddr == motor_pwm_pkg::ADDR_DEAD_TIME) begin
                dead_time_q <= i_pwdata[RW-1:0];
            end
        end
    end
    assign o_timer_run = !stop_q;

    // match events, edge of equality so a held count sets once
    logic peak_eq, trough_eq, peak_hit, trough_hit;
    assign peak_eq = !stop_q && (i_updown_counter == period_cmp_q);
    assign trough_eq = !stop_q && (i_updown_counter == RW'({dead_time_q, 1'b0}));
    assign peak_hit = peak_eq && !peak_eq_q;
    assign trough_hit = trough_eq && !trough_eq_q;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            peak_eq_q <= 1'b0;
            trough_eq_q <= 1'b0;
        end else begin
            peak_eq_q <= peak_eq;
            trough_eq_q <= trough_eq;
        end
    end

    // timer flags: set wins over any clear
    logic wr_flags, rd_flags;
    logic [1:0] tset, tclr;
    assign wr_flags = wr && (i_paddr == motor_pwm_pkg::ADDR_FLAGS);
    assign rd_flags = rd && (i_paddr == motor_pwm_pkg::ADDR_FLAGS);
    assign tset = {trough_hit, peak_hit};
    assign tclr = (wr_flags ? (~i_pwdata[1:0] & tarm_q) : 2'h0)
        | {i_trough_xfer_ack, i_peak_xfer_ack};
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tflag_q <= motor_pwm_pkg::FLAG_RST;
            tarm_q <= motor_pwm_pkg::FLAG_RST;
        end else begin
            tflag_q <= (tflag_q & ~tclr) | tset;
            if (rd_flags) begin
                tarm_q <= rdata_q[1:0];
            end else if (wr_flags) begin
                tarm_q <= motor_pwm_pkg::FLAG_RST;
            end
        end
    end
    assign o_peak_match_irq = tflag_q[motor_pwm_pkg::PEAK_BIT] && irq_en_q[motor_pwm_pkg::PEAK_BIT];
    assign o_trough_match_irq = tflag_q[motor_pwm_pkg::TROUGH_BIT] && irq_en_q[motor_pwm_pkg::TROUGH_BIT];
    assign o_peak_xfer_req = tflag_q[motor_pwm_pkg::PEAK_BIT];
    assign o_trough_xfer_req = tflag_q[motor_pwm_pkg::TROUGH_BIT];

    // buffer and compare registers with write/transfer contention
    logic wr_pbuf, wr_pcmp;
    assign wr_pbuf = wr && (i_paddr == motor_pwm_pkg::ADDR_PERIOD_BUF);
    assign wr_pcmp = wr && (i_paddr == motor_pwm_pkg::ADDR_PERIOD_CMP);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_buf_q <= motor_pwm_pkg::REG_RST;
            period_cmp_q <= motor_pwm_pkg::REG_RST;
        end else begin
            if (wr_pbuf) begin
                period_buf_q <= i_pwdata[RW-1:0];
            end
            if (i_buffer_load && !stop_q) begin
                period_cmp_q <= wr_pbuf ? i_pwdata[RW-1:0] : period_buf_q;
            end else if (wr_pcmp) begin
                period_cmp_q <= i_pwdata[RW-1:0];
            end
        end
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NP; i++) begin
                duty_buf_q[i] <= motor_pwm_pkg::REG_RST;
                duty_cmp_q[i] <= motor_pwm_pkg::REG_RST;
            end
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (wr && hit_dbuf[i]) begin
                    duty_buf_q[i] <= i_pwdata[RW-1:0];
                end
                if (i_buffer_load && !stop_q) begin
                    duty_cmp_q[i] <= (wr && hit_dbuf[i]) ? i_pwdata[RW-1:0] : duty_buf_q[i];
                end else if (wr && hit_dcmp[i]) begin
                    duty_cmp_q[i] <= i_pwdata[RW-1:0];
                end
            end
        end
    end
    assign o_period_compare = period_cmp_q;
    assign o_duty_compare_u = duty_cmp_q[0];
    assign o_duty_compare_v = duty_cmp_q[1];
    assign o_duty_compare_w = duty_cmp_q[2];

    // shutdown inputs: two-flop synchroniser then edge/level detect
    logic [NS-1:0] sd_meta_q, sd_sync_q, sd_prev_q, sd_detect;
    logic [motor_pwm_pkg::PRESC_W-1:0] presc_q;
    logic [motor_pwm_pkg::RUN_W-1:0] run_q [NS];
    logic [NS-1:0] tick;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sd_meta_q <= '1;
            sd_sync_q <= '1;
            sd_prev_q <= '1;
            presc_q <= '0;
        end else begin
            sd_meta_q <= i_shutdown_in_n;
            sd_sync_q <= sd_meta_q;
            sd_prev_q <= sd_sync_q;
            presc_q <= presc_q + motor_pwm_pkg::PRESC_ONE;
        end
    end
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            logic [1:0] m;
            m = sd_mode_q[motor_pwm_pkg::SD_MODE_W*i +: motor_pwm_pkg::SD_MODE_W];
            tick[i] = (presc_q & div_mask(m)) == div_mask(m);
            if (m == motor_pwm_pkg::DET_FALL) begin
                sd_detect[i] = sd_prev_q[i] && !sd_sync_q[i];
            end else begin
                sd_detect[i] = tick[i] && !sd_sync_q[i] && (run_q[i] == motor_pwm_pkg::RUN_LAST);
            end
        end
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NS; i++) begin
                run_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NS; i++) begin
                if (tick[i]) begin
                    // a high sample or a completed run starts over
                    run_q[i] <= (sd_sync_q[i] || run_q[i] == motor_pwm_pkg::RUN_LAST) ? '0
                        : run_q[i] + motor_pwm_pkg::RUN_ONE;
                end
            end
        end
    end

    // shutdown control/status register
    logic wr_sd, rd_sd;
    logic [NS-1:0] sd_clr;
    assign wr_sd = wr && (i_paddr == motor_pwm_pkg::ADDR_SHUTDOWN);
    assign rd_sd = rd && (i_paddr == motor_pwm_pkg::ADDR_SHUTDOWN);
    assign sd_clr = wr_sd ? (~i_pwdata[motor_pwm_pkg::SD_FLAG_LSB +: NS] & sd_arm_q) : '0;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sd_mode_q <= '0;
            sd_pie_q <= 1'b0;
            sd_flag_q <= motor_pwm_pkg::SD_FLAG_RST;
            sd_arm_q <= motor_pwm_pkg::SD_FLAG_RST;
        end else begin
            sd_flag_q <= (sd_flag_q & ~sd_clr) | sd_detect;
            if (wr_sd) begin
                sd_mode_q <= i_pwdata[2*NS-1:0];
                sd_pie_q <= i_pwdata[motor_pwm_pkg::SD_PIE_BIT];
                sd_arm_q <= motor_pwm_pkg::SD_FLAG_RST;
            end else if (rd_sd) begin
                sd_arm_q <= rdata_q[motor_pwm_pkg::SD_FLAG_LSB +: NS];
            end
        end
    end
    assign o_shutdown_irq = sd_pie_q && (|sd_flag_q);

    // hi-z held from flops; reset leaves pins released for safety
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase_out <= '0;
            o_carrier_toggle_out <= 1'b0;
            o_phase_oe_n <= '1;
            o_carrier_oe_n <= 1'b1;
        end else begin
            o_phase_out <= i_phase_level;
            o_carrier_toggle_out <= i_carrier_level;
            o_phase_oe_n <= {NP*2{|sd_flag_q}};
            o_carrier_oe_n <= |sd_flag_q;
        end
    end

    // checks
    a_peak_sets_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        peak_hit |=> tflag_q[motor_pwm_pkg::PEAK_BIT]) else $error("peak match did not set flag");
    a_trough_sets_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        trough_hit |=> o_trough_xfer_req) else $error("trough match did not set flag");
    a_irq_held_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_peak_match_irq && !i_peak_xfer_ack && !wr_flags
        && !(wr && (i_paddr == motor_pwm_pkg::ADDR_IRQ_CTRL)) |=> o_peak_match_irq)
        else $error("peak interrupt dropped while flag set");
    a_clear_needs_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_flags && !tarm_q[0] && tflag_q[0] && !i_peak_xfer_ack |=> tflag_q[0])
        else $error("flag cleared without prior read");
    a_xfer_ack_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_trough_xfer_ack && !trough_hit |=> !o_trough_xfer_req) else $error("transfer did not clear flag");
    a_stop_blocks_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        access && i_pwrite && stop_q && (i_paddr == motor_pwm_pkg::ADDR_DEAD_TIME)
        |-> o_pslverr ##1 $stable(dead_time_q)) else $error("write passed module stop");
    a_buf_write_wins: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_pbuf && i_buffer_load && !stop_q |=> period_cmp_q == $past(i_pwdata[RW-1:0]))
        else $error("buffer write data not transferred");
    a_cmp_write_dropped: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_pcmp && i_buffer_load |=> period_cmp_q == $past(period_buf_q))
        else $error("compare write not dropped");
    a_hiz_on_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        |sd_flag_q |=> (&o_phase_oe_n) && o_carrier_oe_n) else $error("outputs not hi-z");
    a_sd_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !sd_pie_q |-> !o_shutdown_irq) else $error("shutdown irq while disabled");
    a_rsvd_read_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rd_sd |-> o_prdata[motor_pwm_pkg::SD_RSVD_MSB:motor_pwm_pkg::SD_RSVD_LSB] == '0)
        else $error("reserved bits read nonzero");
    a_sd_write_one_keeps: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_sd && sd_flag_q[0] && i_pwdata[motor_pwm_pkg::SD_FLAG_LSB] |=> sd_flag_q[0])
        else $error("writing one cleared shutdown flag");

    c_peak_flag: cover property (@(posedge i_mclk) disable iff (!i_rst_n) peak_hit);
    c_sd_detect: cover property (@(posedge i_mclk) disable iff (!i_rst_n) |sd_detect);
    c_buf_contention: cover property (@(posedge i_mclk) disable iff (!i_rst_n) wr_pbuf && i_buffer_load);
    c_flag_cleared: cover property (@(posedge i_mclk) disable iff (!i_rst_n) |(tclr & tflag_q));
endmodule : motor_pwm_irq_shutoff

`default_nettype wire

// >>> src/motor_pwm_pkg.sv
/*
 * Shared constants for the motor PWM interrupt / output shutoff block:
 * APB byte offsets, field positions, reset values, detect modes.
 * Assumes a 32-bit APB with word-aligned registers and a 40 MHz clock.
 */
package motor_pwm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int NUM_PHASE = 3;
    localparam int NUM_SD = 4;

    localparam logic [ADDR_W-1:0] ADDR_STOP = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_BUF = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_CMP = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DEAD_TIME = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_BUF0 = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_CMP0 = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_SHUTDOWN = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h04;

    localparam int STOP_BIT = 0;
    localparam int PEAK_BIT = 0;
    localparam int TROUGH_BIT = 1;
    localparam int SD_PIE_BIT = 8;
    localparam int SD_RSVD_LSB = 9;
    localparam int SD_RSVD_MSB = 11;
    localparam int SD_FLAG_LSB = 12;
    localparam int SD_MODE_W = 2;

    localparam logic STOP_RST = 1'b1;
    localparam logic [REG_W-1:0] REG_RST = 16'h0000;
    localparam logic [1:0] FLAG_RST = 2'h0;
    localparam logic [NUM_SD-1:0] SD_FLAG_RST = 4'h0;

    typedef enum logic [1:0] {
        DET_FALL = 2'b00,
        DET_DIV8 = 2'b01,
        DET_DIV16 = 2'b10,
        DET_DIV128 = 2'b11
    } detect_mode_type;

    localparam int PRESC_W = 7;
    localparam logic [PRESC_W-1:0] MASK_DIV8 = 7'h07;
    localparam logic [PRESC_W-1:0] MASK_DIV16 = 7'h0f;
    localparam logic [PRESC_W-1:0] MASK_DIV128 = 7'h7f;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 7'h01;
    localparam int RUN_W = 4;
    localparam logic [RUN_W-1:0] RUN_LAST = 4'hf;
    localparam logic [RUN_W-1:0] RUN_ONE = 4'h1;
endpackage : motor_pwm_pkg

// >>> tb/power_stage_model.sv
/* far-side model: four fault lines and the phase level source.
   assumes the bench asks for a low on a line; lines idle high by pull-up. */
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    input wire logic i_mclk,
    input wire logic [3:0] i_pull_low,
    output logic [3:0] o_shutdown_in_n,
    output logic [5:0] o_phase_level,
    output logic o_carrier_level
);
    // released line returns to its pull-up level
    assign o_shutdown_in_n = ~i_pull_low;
    // levels change every cycle so a stuck copy shows
    initial begin
        o_phase_level = 6'h15;
        o_carrier_level = 1'b0;
        forever begin
            @(posedge i_mclk);
            o_phase_level <= ~o_phase_level;
            o_carrier_level <= ~o_carrier_level;
        end
    end
endmodule : power_stage_model
`default_nettype wire

// >>> tb/testbench.sv
/* self-checking bench for the pwm interrupt and output shutoff block.
   assumes zero-wait apb and the power stage model on the fault lines. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ld = 1'b0, pack = 1'b0, tack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, m;
    logic [15:0] cnt = 16'hffff, pcmp, du, dv, dw;
    logic [3:0] low = 4'h0, sd_n;
    logic [5:0] lvl, oe_n, pout;
    logic clvl, pready, pslverr, run, pirq, tirq, preq, treq, sirq, coe_n, ctog;
    int errors = 0, samples_checked = 0;
    int div[4] = '{1, 8, 16, 128};

    motor_pwm_irq_shutoff u_motor_pwm_irq_shutoff (
        .i_mclk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_updown_counter(cnt), .i_buffer_load(ld), .i_peak_xfer_ack(pack), .i_trough_xfer_ack(tack),
        .i_shutdown_in_n(sd_n), .i_phase_level(lvl), .i_carrier_level(clvl), .o_timer_run(run),
        .o_peak_match_irq(pirq), .o_trough_match_irq(tirq), .o_peak_xfer_req(preq), .o_trough_xfer_req(treq),
        .o_shutdown_irq(sirq), .o_period_compare(pcmp), .o_duty_compare_u(du), .o_duty_compare_v(dv),
        .o_duty_compare_w(dw), .o_phase_out(pout), .o_phase_oe_n(oe_n), .o_carrier_toggle_out(ctog),
        .o_carrier_oe_n(coe_n));
    power_stage_model u_power_stage_model (.i_mclk(clk), .i_pull_low(low), .o_shutdown_in_n(sd_n),
        .o_phase_level(lvl), .o_carrier_level(clvl));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic l,
        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        ld <= l;
        @(posedge clk);
        // no wait count assumed: watchdog ends a hang
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        ld <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic l = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, l, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 1'b0, r, e);
        cmp(r, x);
        cmp({31'h0, e}, {31'h0, xe});
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic complete_run;
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // run needs about 3500 cycles
    initial begin
        #500000;
        errors++;
        complete_run();
    end

    initial begin
        tick(4);
        rst_n <= 1'b1;
        rd(8'h30, 32'h0);
        rd(8'h10, 32'h0, 1'b1);
        rd(8'hfc, 32'h0, 1'b1);
        cmp({31'h0, run}, 32'h0);
        wr(8'h14, 32'h7);
        wr(8'h00, 32'h0);
        tick(1);
        cmp({31'h0, run}, 32'h1);
        rd(8'h14, 32'h0);
        // pins copy the levels one cycle late, and the levels invert every cycle
        cmp({25'h0, ctog, pout}, {25'h0, ~clvl, ~lvl});
        wr(8'h04, 32'h3);
        wr(8'h10, 32'h5);
        cnt <= 16'h5;
        tick(3);
        cnt <= 16'hffff;
        cmp({29'h0, preq, tirq, pirq}, 32'h5);
        wr(8'h08, 32'h0);
        tick(1);
        cmp({31'h0, pirq}, 32'h1);
        rd(8'h08, 32'h1);
        wr(8'h08, 32'h0);
        tick(1);
        cmp({30'h0, preq, pirq}, 32'h0);
        wr(8'h14, 32'h3);
        cnt <= 16'h6;
        tick(3);
        cnt <= 16'hffff;
        cmp({30'h0, treq, tirq}, 32'h3);
        tack <= 1'b1;
        tick(1);
        tack <= 1'b0;
        tick(1);
        cmp({30'h0, treq, tirq}, 32'h0);
        wr(8'h0c, 32'h22, 1'b1);
        tick(1);
        cmp({16'h0, pcmp}, 32'h22);
        wr(8'h0c, 32'h33);
        wr(8'h10, 32'h99, 1'b1);
        tick(1);
        cmp({16'h0, pcmp}, 32'h33);
        wr(8'h18, 32'h44, 1'b1);
        wr(8'h1c, 32'h55);
        wr(8'h24, 32'h66, 1'b1);
        wr(8'h2c, 32'h77);
        tick(1);
        cmp({du, dv}, 32'h00440055);
        cmp({16'h0, dw}, 32'h77);
        wr(8'h30, 32'hfe00);
        rd(8'h30, 32'h0);
        // one input per detect mode, each field in its own place
        for (int i = 0; i < 4; i++) begin
            m = 32'h100 | (i << (2 * i));
            wr(8'h30, m);
            low[i] <= 1'b1;
            tick(20 * div[i] + 8);
            cmp({24'h0, coe_n, oe_n, sirq}, 32'hff);
            wr(8'h30, m);
            rd(8'h30, m | (32'h1000 << i));
            wr(8'h30, m | 32'hf000);
            rd(8'h30, m | (32'h1000 << i));
            low[i] <= 1'b0;
            wr(8'h30, m);
            tick(2);
            cmp({24'h0, coe_n, oe_n, sirq}, 32'h0);
        end
        wr(8'h30, 32'h4);
        low[1] <= 1'b1;
        tick(100);
        low[1] <= 1'b0;
        tick(10);
        low[1] <= 1'b1;
        tick(100);
        rd(8'h30, 32'h4);
        tick(60);
        cmp({31'h0, sirq}, 32'h0);
        rd(8'h30, 32'h2004);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
